//--- design/pq_params.svh
// Offsets, field positions, reset values and timing counts of the payload queue link
`ifndef PQ_PARAMS_SVH
`define PQ_PARAMS_SVH
// ***********************************************************************
// Register offsets
// ***********************************************************************
`define PQ_REG_AUTOACK 5'h01
`define PQ_REG_RETRY 5'h04
`define PQ_REG_STATUS 5'h07
`define PQ_REG_QSTAT 5'h17
`define PQ_REG_DYNLEN 5'h1c
`define PQ_REG_FEATURE 5'h1d
`define PQ_REG_IRQMASK 5'h1e
// ***********************************************************************
// Field positions, reset values and minimum retransmit delay
// ***********************************************************************
`define PQ_FEAT_DYNLEN 2
`define PQ_FEAT_ACKPAY 1
`define PQ_FEAT_NOACK 0
`define PQ_QS_TXFULL 5
`define PQ_QS_TXEMPTY 4
`define PQ_QS_RXFULL 1
`define PQ_QS_RXEMPTY 0
`define PQ_ST_RXREADY 6
`define PQ_ST_TXFULL 0
`define PQ_QSTAT_RESET 8'h11
`define PQ_MIN_ARD 4'h1
// ***********************************************************************
// Serial commands
// ***********************************************************************
`define PQ_CMD_RDREG 3'h0
`define PQ_CMD_WRREG 3'h1
`define PQ_CMD_RDRX 8'h61
`define PQ_CMD_WRTX 8'ha0
`define PQ_CMD_WRTX_NOACK 8'hb0
`define PQ_CMD_WRACK 5'h15
// ***********************************************************************
// Sizes and timing
// ***********************************************************************
`define PQ_QDEPTH 3
`define PQ_MAX_BYTES 32
`define PQ_CLK_MHZ 200
`define PQ_LISTEN_US 250
`define PQ_LISTEN_SLOW_US 500
`define PQ_ARD_STEP_US 250
`define PQ_SCLK_HALF 16
`endif

//--- design/pq_pkg.sv
// Types shared by the payload queue ends
package pq_pkg;
    typedef struct packed {
        logic [255:0] payload;
        logic [5:0] len;
        logic [2:0] tag;
    } pq_entry_t;

    typedef struct packed {
        pq_entry_t [2:0] mem;
        logic [1:0] wr;
        logic [1:0] rd;
        logic [1:0] cnt;
    } pq_queue_state_t;

    typedef enum logic [3:0] {
        PQ_T_IDLE = 4'b0001,
        PQ_T_LISTEN = 4'b0010,
        PQ_T_RECV = 4'b0100,
        PQ_T_STBY = 4'b1000
    } pq_timer_e_t;

    typedef struct packed {
        logic [1:0] sclkSync;
        logic [1:0] csSync;
        logic [1:0] mosiSync;
        logic sclkLast;
        logic csLast;
        logic [2:0] bitCnt;
        logic [5:0] byteCnt;
        logic [7:0] shiftIn;
        logic [7:0] txByte;
        logic [7:0] cmd;
        logic miso;
        logic rxTaken;
        logic [255:0] buffer;
        logic [5:0] autoAck;
        logic [5:0] dynlen;
        logic [2:0] feature;
        logic [3:0] auto_retransmit_delay;
        logic rxReady;
        logic rxMask;
        pq_timer_e_t tstate;
        logic [19:0] tcnt;
        logic retransmit;
    } pq_dev_state_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [5:0] len;
        logic [255:0] buffer;
        logic busy;
        logic ending;
        logic done;
        logic mask;
        logic ackShadow;
        logic [4:0] div;
        logic sclk;
        logic csN;
        logic mosi;
        logic [2:0] bitCnt;
        logic [5:0] byteCnt;
        logic [7:0] shOut;
        logic [7:0] shIn;
        logic [1:0] misoSync;
        logic [7:0] rdData;
    } pq_host_state_t;
endpackage

//--- design/pq_link_if.sv
// Serial command link between host and payload queue device
`timescale 1ns/1ps
interface pq_link_if;
    logic sclk;
    logic csN;
    logic mosi;
    logic miso;
    modport host (output sclk, output csN, output mosi, input miso);
    modport device (input sclk, input csN, input mosi, output miso);
endinterface

//--- design/pq_queue.sv
// Three-level payload queue
`timescale 1ns/1ps
`include "pq_params.svh"
module pq_queue (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic push,
    input pq_pkg::pq_entry_t pushEntry,
    input wire logic pop,
    output pq_pkg::pq_entry_t head,
    output logic full,
    output logic empty
);
    pq_pkg::pq_queue_state_t q, d;
    logic pushOk;
    logic popOk;

    assign full = (q.cnt == 2'(`PQ_QDEPTH));
    assign empty = (q.cnt == 2'h0);
    assign head = q.mem[q.rd];
    assign pushOk = push & ~full;
    assign popOk = pop & ~empty;

    always_comb begin
        d = q;
        if (pushOk) begin
            d.mem[q.wr] = pushEntry;
            d.wr = (q.wr == 2'h2) ? 2'h0 : q.wr + 2'h1;
        end
        if (popOk) begin
            d.rd = (q.rd == 2'h2) ? 2'h0 : q.rd + 2'h1;
        end
        unique case ({pushOk, popOk})
            2'b10: d.cnt = q.cnt + 2'h1;
            2'b01: d.cnt = q.cnt - 2'h1;
            default: d.cnt = q.cnt;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

//--- design/pq_device.sv
// Payload queue device: serial command slave, queues, feature registers, retransmit timing
`timescale 1ns/1ps
`include "pq_params.svh"
module pq_device #(
    parameter int LISTEN_CYC = `PQ_LISTEN_US * `PQ_CLK_MHZ,
    parameter int LISTEN_SLOW_CYC = `PQ_LISTEN_SLOW_US * `PQ_CLK_MHZ,
    parameter int ARD_STEP_CYC = `PQ_ARD_STEP_US * `PQ_CLK_MHZ
) (
    input wire logic clock,
    input wire logic rst_n,
    pq_link_if.device link,
    input wire logic primaryReceiver,
    input wire logic rate250k,
    input wire logic rxPush,
    input wire logic [255:0] rxPushPayload,
    input wire logic [5:0] rxPushLen,
    input wire logic [2:0] rxPushPipe,
    input wire logic txPop,
    output logic txAvail,
    output logic [255:0] txHeadPayload,
    output logic [5:0] txHeadLen,
    output logic txHeadNoAck,
    input wire logic ackPop,
    output logic ackAvail,
    output logic [255:0] ackHeadPayload,
    output logic [5:0] ackHeadLen,
    output logic [2:0] ackHeadPipe,
    output logic [5:0] dynlenActive,
    input wire logic txSent,
    input wire logic addrMatch,
    input wire logic pktEnd,
    output logic rxListening,
    output logic standby2,
    output logic retransmit,
    output logic irq
);
    pq_pkg::pq_dev_state_t q, d;
    pq_pkg::pq_entry_t txIn, ackIn, rxIn, txHead, ackHead, rxHead;
    logic txPush, ackPush, rxPop;
    logic txFull, txEmpty, ackFull, ackEmpty, rxFull, rxEmpty;
    logic sclk, rise, fall, csActive, csFall, csRise, byteDone;
    logic [7:0] byteIn, statusByte, qstatByte;
    logic [19:0] listenLimit, ardLimit;
    logic isTxCmd, isAckCmd;

    // ***********************************************************************
    // Queues
    // ***********************************************************************
    pq_queue txQueue (
        .clock(clock), .rst_n(rst_n), .push(txPush), .pushEntry(txIn),
        .pop(txPop & ~primaryReceiver), .head(txHead), .full(txFull), .empty(txEmpty)
    );
    // One global order keeps same-pipe payloads in write order
    pq_queue ackQueue (
        .clock(clock), .rst_n(rst_n), .push(ackPush), .pushEntry(ackIn),
        .pop(ackPop & ackAvail), .head(ackHead), .full(ackFull), .empty(ackEmpty)
    );
    pq_queue rxQueue (
        .clock(clock), .rst_n(rst_n), .push(rxPush), .pushEntry(rxIn),
        .pop(rxPop), .head(rxHead), .full(rxFull), .empty(rxEmpty)
    );

    assign rxIn = '{payload: rxPushPayload, len: rxPushLen, tag: rxPushPipe};
    assign txAvail = ~txEmpty & ~primaryReceiver;
    assign txHeadPayload = txHead.payload;
    assign txHeadLen = txHead.len;
    assign txHeadNoAck = txHead.tag[0];
    assign ackAvail = ~ackEmpty & primaryReceiver & q.feature[`PQ_FEAT_ACKPAY];
    assign ackHeadPayload = ackHead.payload;
    assign ackHeadLen = ackHead.len;
    assign ackHeadPipe = ackHead.tag;
    assign dynlenActive = q.dynlen & q.autoAck & {6{q.feature[`PQ_FEAT_DYNLEN]}};
    assign rxListening = (q.tstate == pq_pkg::PQ_T_LISTEN) | (q.tstate == pq_pkg::PQ_T_RECV);
    assign standby2 = (q.tstate == pq_pkg::PQ_T_STBY);
    assign retransmit = q.retransmit;
    assign irq = q.rxReady & q.rxMask;
    assign link.miso = q.miso;

    // ***********************************************************************
    // Register view
    // ***********************************************************************
    assign statusByte = {1'b0, q.rxReady, 5'h00, txFull};
    assign qstatByte = {2'b00, txFull, txEmpty, 2'b00, rxFull, rxEmpty};

    function automatic logic [7:0] readReg(input logic [4:0] a);
        unique case (a)
            `PQ_REG_AUTOACK: readReg = {2'b00, q.autoAck};
            `PQ_REG_RETRY: readReg = {q.auto_retransmit_delay, 4'h0};
            `PQ_REG_STATUS: readReg = statusByte;
            `PQ_REG_QSTAT: readReg = qstatByte;
            `PQ_REG_DYNLEN: readReg = {2'b00, q.dynlen};
            `PQ_REG_FEATURE: readReg = {5'h00, q.feature};
            `PQ_REG_IRQMASK: readReg = {1'b0, q.rxMask, 6'h00};
            default: readReg = 8'h00;
        endcase
    endfunction

    assign sclk = q.sclkSync[1];
    assign rise = sclk & ~q.sclkLast;
    assign fall = ~sclk & q.sclkLast;
    assign csActive = ~q.csSync[1];
    assign csFall = ~q.csSync[1] & q.csLast;
    assign csRise = q.csSync[1] & ~q.csLast;
    assign byteIn = {q.shiftIn[6:0], q.mosiSync[1]};
    assign byteDone = csActive & rise & (q.bitCnt == 3'h7);
    assign isTxCmd = (q.cmd == `PQ_CMD_WRTX) |
        ((q.cmd == `PQ_CMD_WRTX_NOACK) & q.feature[`PQ_FEAT_NOACK]);
    assign isAckCmd = (q.cmd[7:3] == `PQ_CMD_WRACK);
    assign listenLimit = rate250k ? 20'(LISTEN_SLOW_CYC) : 20'(LISTEN_CYC);
    assign ardLimit = 20'(({16'h0000, q.auto_retransmit_delay} + 20'h1) * 20'(ARD_STEP_CYC));

    // ***********************************************************************
    // Next state
    // ***********************************************************************
    always_comb begin
        d = q;
        txPush = 1'b0;
        ackPush = 1'b0;
        rxPop = 1'b0;
        d.sclkSync = {q.sclkSync[0], link.sclk};
        d.csSync = {q.csSync[0], link.csN};
        d.mosiSync = {q.mosiSync[0], link.mosi};
        d.sclkLast = sclk;
        d.csLast = q.csSync[1];
        d.retransmit = 1'b0;
        if (csFall) begin
            d.bitCnt = 3'h0;
            d.byteCnt = 6'h00;
            d.cmd = 8'h00;
            d.txByte = statusByte;
            d.miso = statusByte[7];
            d.rxTaken = 1'b0;
        end else if (csActive & rise) begin
            d.shiftIn = byteIn;
            d.bitCnt = q.bitCnt + 3'h1;
        end else if (csActive & fall) begin
            d.miso = q.txByte[3'h7 - q.bitCnt];
        end
        if (byteDone) begin
            if (q.byteCnt == 6'h00) begin
                d.cmd = byteIn;
                if (byteIn[7:5] == `PQ_CMD_RDREG) begin
                    d.txByte = readReg(byteIn[4:0]);
                end else if (byteIn == `PQ_CMD_RDRX) begin
                    d.txByte = rxHead.payload[7:0];
                    d.rxTaken = ~rxEmpty;
                end else begin
                    d.txByte = 8'h00;
                end
            end else begin
                if ((q.cmd[7:5] == `PQ_CMD_WRREG) && (q.byteCnt == 6'h01)) begin
                    unique case (q.cmd[4:0])
                        `PQ_REG_AUTOACK: d.autoAck = byteIn[5:0];
                        `PQ_REG_RETRY: d.auto_retransmit_delay = byteIn[7:4];
                        `PQ_REG_STATUS: d.rxReady = q.rxReady & ~byteIn[`PQ_ST_RXREADY];
                        `PQ_REG_DYNLEN: d.dynlen = byteIn[5:0];
                        `PQ_REG_FEATURE: d.feature = byteIn[2:0];
                        `PQ_REG_IRQMASK: d.rxMask = byteIn[`PQ_ST_RXREADY];
                        default: d.rxMask = q.rxMask;
                    endcase
                end
                if (q.byteCnt <= 6'(`PQ_MAX_BYTES)) begin
                    d.buffer[{q.byteCnt[4:0] - 5'h01, 3'h0} +: 8] = byteIn;
                end
                // The first byte past the entry wraps to the start of the oldest payload; later ones repeat its second byte
                d.txByte = rxHead.payload[{q.byteCnt[4:0], 3'h0} +: 8];
            end
            if (q.byteCnt <= 6'(`PQ_MAX_BYTES)) begin
                d.byteCnt = q.byteCnt + 6'h01;
            end
        end
        txIn = '{payload: q.buffer, len: q.byteCnt - 6'h01,
            tag: {2'b00, q.cmd == `PQ_CMD_WRTX_NOACK}};
        ackIn = '{payload: q.buffer, len: q.byteCnt - 6'h01, tag: q.cmd[2:0]};
        if (csRise && (q.byteCnt >= 6'h02)) begin
            txPush = isTxCmd;
            ackPush = isAckCmd;
        end
        if (csRise && q.rxTaken) begin
            rxPop = 1'b1;
        end
        if (csRise) begin
            d.cmd = 8'h00;
        end
        if (rxPush & ~rxFull) begin
            d.rxReady = 1'b1;
        end
        // Retransmit wait
        d.tcnt = q.tcnt + 20'h1;
        unique case (q.tstate)
            pq_pkg::PQ_T_IDLE: d.tcnt = 20'h0;
            pq_pkg::PQ_T_LISTEN: begin
                if (addrMatch) begin
                    d.tstate = pq_pkg::PQ_T_RECV;
                end else if (q.tcnt >= listenLimit - 20'h1) begin
                    d.tstate = pq_pkg::PQ_T_STBY;
                end
            end
            pq_pkg::PQ_T_RECV: begin
                if (pktEnd) begin
                    d.tstate = pq_pkg::PQ_T_STBY;
                end else if (q.tcnt >= ardLimit - 20'h1) begin
                    d.tstate = pq_pkg::PQ_T_IDLE;
                    d.retransmit = 1'b1;
                end
            end
            pq_pkg::PQ_T_STBY: begin
                if (q.tcnt >= ardLimit - 20'h1) begin
                    d.tstate = pq_pkg::PQ_T_IDLE;
                    d.retransmit = 1'b1;
                end
            end
            default: d.tstate = pq_pkg::PQ_T_IDLE;
        endcase
        if (txSent) begin
            d.tstate = pq_pkg::PQ_T_LISTEN;
            d.tcnt = 20'h0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.sclkSync <= 2'b00;
            q.csSync <= 2'b11;
            q.csLast <= 1'b1;
            q.tstate <= pq_pkg::PQ_T_IDLE;
        end else begin
            q <= d;
        end
    end
endmodule

//--- design/pq_host.sv
// Host end: software register window driving the serial command link
`timescale 1ns/1ps
`include "pq_params.svh"
module pq_host (
    input wire logic clock,
    input wire logic rst_n,
    pq_link_if.host link,
    input wire logic [5:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdData,
    output logic irq
);
    localparam logic [5:0] HR_START = 6'h00;
    localparam logic [5:0] HR_LEN = 6'h01;
    localparam logic [5:0] HR_STATUS = 6'h02;
    localparam logic [5:0] HR_MASK = 6'h03;
    pq_pkg::pq_host_state_t q, d;
    logic tick;
    logic [7:0] nextByte;

    assign link.sclk = q.sclk;
    assign link.csN = q.csN;
    assign link.mosi = q.mosi;
    assign rdData = q.rdData;
    assign irq = q.done & q.mask;
    assign tick = (q.div == 5'(`PQ_SCLK_HALF - 1));

    // Guards on configuration bytes on their way out
    function automatic logic [7:0] guardByte(input logic [7:0] op, input logic [7:0] b,
                                             input logic ackOn);
        logic [7:0] g;
        g = b;
        if (op == {`PQ_CMD_WRREG, `PQ_REG_DYNLEN}) begin
            g[7:6] = 2'b00;
            g[0] = b[0] | ackOn;
        end
        if ((op == {`PQ_CMD_WRREG, `PQ_REG_RETRY}) && (b[7:4] < `PQ_MIN_ARD)) begin
            g[7:4] = `PQ_MIN_ARD;
        end
        guardByte = g;
    endfunction

    assign nextByte = guardByte(q.opcode, q.buffer[{q.byteCnt[4:0], 3'h0} +: 8], q.ackShadow);

    always_comb begin
        d = q;
        d.misoSync = {q.misoSync[0], link.miso};
        d.rdData = 8'h00;
        if (rdStb) begin
            unique case (addr)
                HR_LEN: d.rdData = {2'b00, q.len};
                HR_STATUS: d.rdData = {6'h00, q.done, q.busy};
                HR_MASK: d.rdData = {6'h00, q.mask, 1'b0};
                default: d.rdData = addr[5] ? q.buffer[{addr[4:0], 3'h0} +: 8] : 8'h00;
            endcase
        end
        if (q.busy) begin
            d.div = tick ? 5'h00 : q.div + 5'h01;
        end
        if (q.busy && tick) begin
            if (q.ending) begin
                d.busy = 1'b0;
                d.ending = 1'b0;
            end else if (!q.sclk) begin
                d.sclk = 1'b1;
                d.shIn = {q.shIn[6:0], q.misoSync[1]};
            end else begin
                d.sclk = 1'b0;
                d.bitCnt = q.bitCnt + 3'h1;
                if (q.bitCnt == 3'h7) begin
                    if (q.byteCnt != 6'h00) begin
                        d.buffer[{q.byteCnt[4:0] - 5'h01, 3'h0} +: 8] = q.shIn;
                    end
                    if (q.byteCnt == q.len) begin
                        d.csN = 1'b1;
                        d.ending = 1'b1;
                        d.done = 1'b1;
                    end else begin
                        d.byteCnt = q.byteCnt + 6'h01;
                        d.shOut = nextByte;
                        d.mosi = nextByte[7];
                    end
                end else begin
                    d.shOut = {q.shOut[6:0], 1'b0};
                    d.mosi = q.shOut[6];
                end
            end
        end
        if (wrStb) begin
            unique case (addr)
                HR_START: begin
                    if (!q.busy) begin
                        d.opcode = wrData;
                        d.busy = 1'b1;
                        d.csN = 1'b0;
                        d.shOut = wrData;
                        d.mosi = wrData[7];
                        d.bitCnt = 3'h0;
                        d.byteCnt = 6'h00;
                        d.div = 5'h00;
                    end
                end
                HR_LEN: d.len = (wrData[5:0] > 6'(`PQ_MAX_BYTES)) ?
                    6'(`PQ_MAX_BYTES) : wrData[5:0];
                HR_STATUS: d.done = q.done & ~wrData[1];
                HR_MASK: d.mask = wrData[1];
                default: begin
                    if (addr[5] && !q.busy) begin
                        d.buffer[{addr[4:0], 3'h0} +: 8] = wrData;
                    end
                end
            endcase
        end
        if (wrStb && (addr == HR_START) && !q.busy &&
            (wrData == {`PQ_CMD_WRREG, `PQ_REG_FEATURE})) begin
            d.ackShadow = q.buffer[`PQ_FEAT_ACKPAY];
        end
        if (q.busy && tick && q.sclk && (q.bitCnt == 3'h7) && (q.byteCnt == q.len)) begin
            d.done = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.csN <= 1'b1;
        end else begin
            q <= d;
        end
    end
endmodule

//--- dv/pq_link_assertions.sv
// Assertions on the serial link joining host and device ends
`timescale 1ns/1ps
module pq_link_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic csN,
    input wire logic mosi,
    input wire logic miso
);
    // ********
    // Link timing
    // ********
    logic [2:0] bitCnt_q;
    logic sclk_q;
    // Rises counted mod 8, so a frame must close on a byte boundary
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_q <= 3'h0;
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
            if (csN)
                bitCnt_q <= 3'h0;
            else if (sclk && !sclk_q)
                bitCnt_q <= bitCnt_q + 3'h1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sclk_idle_a: assert property (csN |-> !sclk)
        else $error("serial clock high outside a frame");
    frame_lead_a: assert property ($fell(csN) |-> !sclk [*8])
        else $error("serial clock rose too soon after select");
    half_period_a: assert property ($changed(sclk) |=> $stable(sclk) [*8])
        else $error("serial clock half period too short");
    mosi_steady_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data moved while clock high");
    mosi_edge_a: assert property ($changed(mosi) |-> !sclk)
        else $error("host data moved on a high clock");
    miso_steady_a: assert property (sclk && $past(sclk) |-> $stable(miso))
        else $error("device data moved while clock high");
    select_gap_a: assert property ($rose(csN) |=> csN [*3])
        else $error("select gap too short");
    whole_bytes_a: assert property ($rose(csN) |-> bitCnt_q == 3'h0)
        else $error("frame ended inside a byte");
    cover property ($rose(csN) && bitCnt_q == 3'h0);
    cover property ($fell(csN) ##[1:1000] sclk);
    cover property (!csN && miso);
endmodule

//--- dv/tb_payload_queues_and_dynamic_length.sv
// Bench joining host and device ends through the link interface
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin badCount++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
`define SEE(g, e) begin @(negedge clock); `CHK(g, e) @(posedge clock); end
module tb_payload_queues_and_dynamic_length;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wrData = 8'h00;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    logic rdV = 1'b0;
    logic primaryReceiver = 1'b0;
    logic rate250k = 1'b0;
    logic [5:0] ev = 6'h00;
    logic [255:0] rxPay = 256'h0;
    logic [5:0] rxLen = 6'h00;
    logic [7:0] rdData, expNow;
    logic hIrq, txAvail, txHeadNoAck, ackAvail, retransmit, rxListening, standby2, devIrq;
    logic [255:0] txHeadPayload, ackHeadPayload;
    logic [5:0] txHeadLen, dynlenActive, ackHeadLen;
    logic [2:0] ackHeadPipe;
    logic [7:0] expQ[$];
    logic [31:0] seed = 32'hc3101d6c;
    int badCount = 0;
    int checks = 0;
    pq_link_if pq_link_if_inst ();
    pq_host pq_host_inst (.clock(clock), .rst_n(rst_n), .link(pq_link_if_inst), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(hIrq));
    pq_device #(.LISTEN_CYC(20), .LISTEN_SLOW_CYC(40), .ARD_STEP_CYC(30)) pq_device_inst (
        .clock(clock), .rst_n(rst_n), .link(pq_link_if_inst), .primaryReceiver(primaryReceiver),
        .rate250k(rate250k), .rxPush(ev[5]), .rxPushPayload(rxPay), .rxPushLen(rxLen),
        .rxPushPipe(3'h2), .txPop(ev[0]), .txAvail(txAvail), .txHeadPayload(txHeadPayload),
        .txHeadLen(txHeadLen), .txHeadNoAck(txHeadNoAck), .ackPop(ev[1]), .ackAvail(ackAvail),
        .ackHeadPayload(ackHeadPayload), .ackHeadLen(ackHeadLen), .ackHeadPipe(ackHeadPipe),
        .dynlenActive(dynlenActive), .txSent(ev[2]), .addrMatch(ev[3]), .pktEnd(ev[4]),
        .rxListening(rxListening), .standby2(standby2), .retransmit(retransmit), .irq(devIrq));
    pq_link_assertions pq_link_assertions_inst (.clock(clock), .rst_n(rst_n),
        .sclk(pq_link_if_inst.sclk), .csN(pq_link_if_inst.csN),
        .mosi(pq_link_if_inst.mosi), .miso(pq_link_if_inst.miso));
    // ********
    // Drivers and monitor
    // ********
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        rdStb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        addr <= a;
        rdStb <= 1'b1;
        wrStb <= 1'b0;
        expQ.push_back(e);
        @(posedge clock);
    endtask
    task automatic idle(input int n);
        wrStb <= 1'b0;
        rdStb <= 1'b0;
        ev <= 6'h00;
        repeat (n) @(posedge clock);
    endtask
    task automatic pulse(input logic [5:0] m);
        ev <= m;
        wrStb <= 1'b0;
        rdStb <= 1'b0;
        @(posedge clock);
        idle(1);
    endtask
    // Done is cleared each time, so each run waits for a fresh rise of the host interrupt
    task automatic run(input logic [7:0] op, input logic [7:0] n);
        wr(6'h01, n);
        wr(6'h03, 8'h02);
        wr(6'h00, op);
        idle(1);
        for (int i = 0; i < 20000 && hIrq !== 1'b1; i++) @(posedge clock);
        if (hIrq !== 1'b1) badCount++;
        wr(6'h02, 8'h02);
        idle(20);
    endtask
    task automatic setreg(input logic [4:0] a, input logic [7:0] v);
        wr(6'h20, v);
        run({3'h1, a}, 8'h01);
    endtask
    task automatic getreg(input logic [4:0] a, input logic [7:0] e);
        run({3'h0, a}, 8'h01);
        rd(6'h20, e);
        idle(1);
    endtask
    task automatic fill(input int n, output logic [255:0] p);
        p = 256'h0;
        for (int j = 0; j < n; j++) begin
            p[8*j+:8] = rnd();
            wr(6'h20 + 6'(j), p[8*j+:8]);
        end
    endtask
    task automatic waitRt();
        for (int i = 0; i < 200 && retransmit !== 1'b1; i++) @(posedge clock);
    endtask
    task automatic conclude();
        if (badCount == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        if (rdV) begin
            expNow = expQ.pop_front();
            `CHK(rdData, expNow)
        end
        rdV <= rdStb;
    end
    initial begin
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (90000) @(posedge clock);
        badCount++;
        conclude();
    end
    // ********
    // Scenarios
    // ********
    initial begin
        logic [255:0] p [4];
        int lens [4] = '{32, 1, 5, 2};
        int pipes [4] = '{3, 0, 5, 1};
        time t0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        idle(1);
        getreg(5'h17, 8'h11);
        getreg(5'h1d, 8'h00);
        getreg(5'h1c, 8'h00);
        setreg(5'h01, 8'h3f);
        setreg(5'h1d, 8'h04);
        setreg(5'h1c, 8'hc5);
        `SEE(dynlenActive, 6'h05)
        getreg(5'h1c, 8'h05);
        setreg(5'h01, 8'h01);
        `SEE(dynlenActive, 6'h01)
        setreg(5'h1d, 8'h03);
        `SEE(dynlenActive, 6'h00)
        getreg(5'h1d, 8'h03);
        for (int i = 0; i < 4; i++) begin
            fill(lens[i], p[i]);
            run((i == 1) ? 8'hb0 : 8'ha0, 8'(lens[i]));
        end
        getreg(5'h17, 8'h21);
        // A pop in receive mode must leave the head alone
        primaryReceiver <= 1'b1;
        pulse(6'h01);
        primaryReceiver <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            `SEE(txHeadLen, 6'(lens[i]))
            `SEE(txHeadPayload & ((256'h1 << 8 * lens[i]) - 256'h1), p[i])
            `SEE(txHeadNoAck, i == 1)
            pulse(6'h01);
        end
        `SEE(txAvail, 1'b0)
        setreg(5'h1d, 8'h06);
        run(8'hb0, 8'h01);
        `SEE(txAvail, 1'b0)
        setreg(5'h1c, 8'h00);
        getreg(5'h1c, 8'h01);
        primaryReceiver <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            fill(2, p[i]);
            run(8'ha8 | 8'(pipes[i]), 8'h02);
        end
        for (int i = 0; i < 3; i++) begin
            `SEE(ackHeadPipe, 3'(pipes[i]))
            `SEE(ackHeadLen, 6'h02)
            `SEE(ackHeadPayload[15:0], p[i][15:0])
            pulse(6'h02);
        end
        `SEE(ackAvail, 1'b0)
        for (int i = 0; i < 4; i++) begin
            fill(lens[i], p[i]);
            rxPay <= p[i];
            rxLen <= 6'(lens[i]);
            pulse(6'h20);
        end
        `SEE(devIrq, 1'b0)
        setreg(5'h1e, 8'h40);
        `SEE(devIrq, 1'b1)
        getreg(5'h17, 8'h12);
        for (int i = 0; i < 3; i++) begin
            run(8'h61, 8'(lens[i]));
            for (int j = 0; j < lens[i]; j++) rd(6'h20 + 6'(j), p[i][8*j+:8]);
            setreg(5'h07, 8'h40);
            `SEE(devIrq, 1'b0)
            getreg(5'h17, (i == 2) ? 8'h11 : 8'h10);
        end
        setreg(5'h04, 8'h00);
        t0 = $time;
        pulse(6'h04);
        `SEE(rxListening, 1'b1)
        repeat (25) @(posedge clock);
        `SEE(standby2, 1'b1)
        waitRt();
        `CHK(($time - t0) / 5 inside {[58:66]}, 1'b1)
        rate250k <= 1'b1;
        pulse(6'h04);
        repeat (25) @(posedge clock);
        `SEE(standby2, 1'b0)
        t0 = $time;
        pulse(6'h04);
        pulse(6'h08);
        repeat (20) @(posedge clock);
        `SEE(standby2, 1'b0)
        `SEE(rxListening, 1'b1)
        pulse(6'h10);
        `SEE(standby2, 1'b1)
        waitRt();
        `CHK(($time - t0) / 5 inside {[58:66]}, 1'b1)
        idle(5);
        conclude();
    end
endmodule
